// ==== rtl/pps_pkg.sv ====
package pps_pkg;
    localparam logic [3:0] CMD_CFG_READ = 4'hA;
    localparam logic [3:0] CMD_CFG_WRITE = 4'hB;
    localparam logic [1:0] CFG_TYPE0 = 2'h0;
    localparam logic [3:0] BYTE_EN_ALL = 4'h0;
    localparam logic [31:0] AD_PARK = 32'h0;
    localparam logic [3:0] CBE_PARK = 4'h0;
    localparam logic [2:0] CLAIM_LIMIT = 3'h5;
    localparam logic [1:0] REQ_GAP = 2'h2;
    localparam logic [7:0] STATUS_CMD_OFFSET = 8'h04;
    localparam int SPEED_CAP_BIT = 21;
    localparam logic [4:0] REG_CTRL = 5'h00;
    localparam logic [4:0] REG_ADDR = 5'h04;
    localparam logic [4:0] REG_DATA = 5'h08;
    localparam logic [4:0] REG_CMD = 5'h0C;
    localparam logic [4:0] REG_STATUS = 5'h10;
    localparam logic [4:0] REG_BUS = 5'h14;
    localparam int CTRL_W = 11;
    localparam int CTRL_GRANT = 0;
    localparam int CTRL_CFG_SEL = 1;
    localparam int CTRL_LOCK = 2;
    localparam int CTRL_SPEED = 3;
    localparam int CTRL_CLAIM_EN = 4;
    localparam int CTRL_DELAY = 5;
    localparam int CTRL_BAD_ADDR_PAR = 8;
    localparam int CTRL_BAD_DATA_PAR = 9;
    localparam int CTRL_SERR = 10;
    localparam int STAT_CMD_BUSY = 4;
    localparam int STAT_SEEN = 3;

    typedef enum logic [2:0] {M_IDLE, M_REQ, M_ADDR, M_DATA, M_TURN} pps_mst_type;
    typedef enum logic [1:0] {H_IDLE, H_ADDR, H_DATA, H_TURN} pps_hst_type;

    typedef struct packed {
        pps_mst_type mst;
        logic [1:0] gap;
        logic [2:0] wait_cnt;
        logic [31:0] tx_addr;
        logic [3:0] tx_cmd;
        logic [31:0] tx_data;
        logic tx_posted;
        logic [31:0] ad_o;
        logic [3:0] cbe_o;
        logic ad_oe_n;
        logic par_o;
        logic par_oe_n;
        logic frame_o;
        logic frame_oe_n;
        logic irdy_o;
        logic irdy_oe_n;
        logic req_o;
        logic req_oe_n;
        logic perr_o;
        logic perr_oe_n;
        logic serr_oe_n;
        logic prev_frame_n;
        logic [31:0] snap_ad;
        logic [3:0] snap_cbe;
        logic chk_addr;
        logic chk_data;
        logic claim;
        logic claim_wr;
        logic done;
        logic abort;
        logic locked;
        logic speed_cap;
        logic sspeed_oe_n;
    } pps_dev_state_type;

    localparam pps_dev_state_type DEV_RESET = '{mst: M_IDLE, ad_oe_n: 1'b1, par_oe_n: 1'b1,
        frame_o: 1'b1, frame_oe_n: 1'b1, irdy_o: 1'b1, irdy_oe_n: 1'b1, req_o: 1'b1,
        req_oe_n: 1'b1, perr_o: 1'b1, perr_oe_n: 1'b1, serr_oe_n: 1'b1,
        prev_frame_n: 1'b1, sspeed_oe_n: 1'b1, default: '0};

    typedef struct packed {
        pps_hst_type hst;
        logic [CTRL_W-1:0] ctrl;
        logic [31:0] addr;
        logic [31:0] data;
        logic [3:0] cmd;
        logic pending;
        logic [31:0] ad_o;
        logic [3:0] cbe_o;
        logic ad_oe_n;
        logic par_o;
        logic par_oe_n;
        logic frame_o;
        logic frame_oe_n;
        logic irdy_o;
        logic irdy_oe_n;
        logic devsel_o;
        logic devsel_oe_n;
        logic armed;
        logic [2:0] claim_cnt;
        logic prev_frame_n;
        logic [2:0] seen;
        logic ack;
        logic [31:0] rdata;
        logic [31:0] bus_ad;
    } pps_host_state_type;

    localparam pps_host_state_type HOST_RESET = '{hst: H_IDLE, ad_oe_n: 1'b1, par_oe_n: 1'b1,
        frame_o: 1'b1, frame_oe_n: 1'b1, irdy_o: 1'b1, irdy_oe_n: 1'b1, devsel_o: 1'b1,
        devsel_oe_n: 1'b1, prev_frame_n: 1'b1, default: '0};

    function automatic logic pps_parity(input logic [31:0] ad, input logic [3:0] cbe);
        pps_parity = ^{ad, cbe};
    endfunction
endpackage

// ==== rtl/pps_link_if.sv ====
`timescale 1ns/100ps
interface pps_link_if;
    logic [31:0] dev_ad_o, host_ad_o, bus_ad;
    logic [3:0] dev_cbe_o, host_cbe_o, primary_cmd_byte_en;
    logic dev_ad_oe_n, host_ad_oe_n, dev_par_o, host_par_o, dev_par_oe_n, host_par_oe_n;
    logic dev_frame_o, dev_frame_oe_n, host_frame_o, host_frame_oe_n;
    logic dev_irdy_o, dev_irdy_oe_n, host_irdy_o, host_irdy_oe_n;
    logic dev_req_o, dev_req_oe_n, dev_perr_o, dev_perr_oe_n;
    logic dev_serr_o, dev_serr_oe_n, host_serr_o, host_serr_oe_n;
    logic host_lock_o, host_lock_oe_n, host_devsel_o, host_devsel_oe_n;
    logic bus_gnt_n, primary_config_select, primary_speed_select;
    logic primary_parity, frame_n, irdy_n, lock_n, bus_req_n;
    logic primary_parity_err_n, primary_system_err_n, primary_target_claim_n;

    // Wire resolution; undriven lines float high on their pull-ups
    assign bus_ad = !dev_ad_oe_n ? dev_ad_o : (!host_ad_oe_n ? host_ad_o : '1);
    assign primary_cmd_byte_en = !dev_ad_oe_n ? dev_cbe_o : (!host_ad_oe_n ? host_cbe_o : '1);
    assign primary_parity = !dev_par_oe_n ? dev_par_o : (!host_par_oe_n ? host_par_o : 1'b1);
    assign frame_n = !dev_frame_oe_n ? dev_frame_o : (!host_frame_oe_n ? host_frame_o : 1'b1);
    assign irdy_n = !dev_irdy_oe_n ? dev_irdy_o : (!host_irdy_oe_n ? host_irdy_o : 1'b1);
    assign lock_n = host_lock_oe_n | host_lock_o;
    assign bus_req_n = dev_req_oe_n | dev_req_o;
    assign primary_parity_err_n = dev_perr_oe_n | dev_perr_o;
    assign primary_target_claim_n = host_devsel_oe_n | host_devsel_o;
    assign primary_system_err_n = (dev_serr_oe_n | dev_serr_o) & (host_serr_oe_n | host_serr_o);

    modport bridge (
        input bus_ad, primary_cmd_byte_en, primary_parity, frame_n, irdy_n, lock_n,
        input bus_gnt_n, primary_config_select, primary_speed_select, primary_target_claim_n,
        output dev_ad_o, dev_cbe_o, dev_ad_oe_n, dev_par_o, dev_par_oe_n,
        output dev_frame_o, dev_frame_oe_n, dev_irdy_o, dev_irdy_oe_n,
        output dev_req_o, dev_req_oe_n, dev_perr_o, dev_perr_oe_n, dev_serr_o, dev_serr_oe_n
    );
    modport host (
        input bus_ad, primary_cmd_byte_en, primary_parity, frame_n, irdy_n,
        input bus_req_n, primary_parity_err_n, primary_system_err_n,
        output host_ad_o, host_cbe_o, host_ad_oe_n, host_par_o, host_par_oe_n,
        output host_frame_o, host_frame_oe_n, host_irdy_o, host_irdy_oe_n,
        output host_serr_o, host_serr_oe_n, host_lock_o, host_lock_oe_n,
        output host_devsel_o, host_devsel_oe_n,
        output bus_gnt_n, primary_config_select, primary_speed_select
    );
endinterface

// ==== rtl/pps_bridge_end.sv ====
// Implementation choices: the Avalon-MM slave port and the register offsets.
`timescale 1ns/100ps
// Overview of operation
// - Master holds lock low across exclusive sequence
// - Config select gates Type 0 configuration claims
// - Assert parity error on bad received data
// - Drive parity error high one cycle, release
// - System error only pulled low or released
// - System error: address, posted data, secondary
// - System error: posted write aborts or discards
// - System error: delayed request discarded
// - System error: delayed transaction master timeout
// - Request low when wanting to initiate
// - Request stays high two clocks minimum
// - Start transaction only while granted
// - Park address, command, parity when idle granted
// - Reset releases all bus outputs asynchronously
// - Speed select high 66MHz, low 33MHz
// - Synchronous mode drives secondary speed low
// - Synchronous mode status bit from config option
// - Asynchronous mode status bit from speed pin
// - Master abort without claim within five cycles
module pps_bridge_end
(
    input logic clk,
    input logic rst,
    pps_link_if.bridge link,
    input logic mst_start,
    input logic [31:0] mst_addr,
    input logic [3:0] mst_cmd,
    input logic [31:0] mst_data,
    input logic mst_posted,
    output logic mst_busy,
    output logic mst_done,
    output logic mst_abort,
    output logic cfg_claim,
    output logic cfg_claim_write,
    output logic bus_locked,
    input logic posted_tgt_parity_err,
    input logic posted_target_abort,
    input logic posted_discard,
    input logic delayed_write_discard,
    input logic delayed_read_discard,
    input logic delayed_master_timeout,
    input logic secondary_system_err_n,
    input logic async_mode,
    input logic config_speed_option,
    output logic secondary_speed_select_o,
    output logic secondary_speed_select_oe_n,
    output logic [31:0] status_cmd_word
);
    import pps_pkg::*;

    pps_dev_state_type s;
    pps_dev_state_type next_s;
    logic bus_idle;
    logic park;
    logic addr_err;
    logic data_err;
    logic serr_event;
    logic [3:0] cmd_in;

    always_comb
    begin
        next_s = s;
        cmd_in = link.primary_cmd_byte_en;
        bus_idle = link.frame_n & link.irdy_n;
        park = !link.bus_gnt_n && bus_idle;
        next_s.claim = 1'b0;
        next_s.claim_wr = 1'b0;
        next_s.done = 1'b0;
        next_s.abort = 1'b0;
        next_s.chk_addr = 1'b0;
        next_s.chk_data = 1'b0;
        next_s.req_oe_n = 1'b0;
        next_s.prev_frame_n = link.frame_n;
        if (s.gap != 2'h0)
        begin
            next_s.gap = s.gap - 2'h1;
        end
        // Another master starts an address phase
        if (s.prev_frame_n && !link.frame_n && s.frame_oe_n)
        begin
            next_s.snap_ad = link.bus_ad;
            next_s.snap_cbe = cmd_in;
            next_s.chk_addr = 1'b1;
            next_s.locked = !link.lock_n;
            if (link.primary_config_select && link.bus_ad[1:0] == CFG_TYPE0 &&
                (cmd_in == CMD_CFG_READ || cmd_in == CMD_CFG_WRITE))
            begin
                next_s.claim = 1'b1;
                next_s.claim_wr = cmd_in == CMD_CFG_WRITE;
            end
        end
        if (link.lock_n && bus_idle)
        begin
            next_s.locked = 1'b0;
        end
        // Data received from another master
        if (!link.irdy_n && s.irdy_oe_n)
        begin
            next_s.snap_ad = link.bus_ad;
            next_s.snap_cbe = cmd_in;
            next_s.chk_data = 1'b1;
        end
        addr_err = s.chk_addr && (pps_parity(s.snap_ad, s.snap_cbe) != link.primary_parity);
        data_err = s.chk_data && (pps_parity(s.snap_ad, s.snap_cbe) != link.primary_parity);
        if (data_err)
        begin
            next_s.perr_o = 1'b0;
            next_s.perr_oe_n = 1'b0;
        end
        else if (!s.perr_oe_n && !s.perr_o)
        begin
            next_s.perr_o = 1'b1;
        end
        else
        begin
            next_s.perr_oe_n = 1'b1;
        end
        // Parity trails address and data by one clock
        next_s.par_o = pps_parity(s.ad_o, s.cbe_o);
        next_s.par_oe_n = s.ad_oe_n;
        case (s.mst)
            M_IDLE, M_REQ:
            begin
                next_s.ad_oe_n = !park;
                next_s.ad_o = AD_PARK;
                next_s.cbe_o = CBE_PARK;
                if (s.mst == M_IDLE && mst_start && s.gap == 2'h0)
                begin
                    next_s.tx_addr = mst_addr;
                    next_s.tx_cmd = mst_cmd;
                    next_s.tx_data = mst_data;
                    next_s.tx_posted = mst_posted;
                    next_s.req_o = 1'b0;
                    next_s.mst = M_REQ;
                end
                if (s.mst == M_REQ && park)
                begin
                    next_s.frame_o = 1'b0;
                    next_s.frame_oe_n = 1'b0;
                    next_s.ad_o = s.tx_addr;
                    next_s.cbe_o = s.tx_cmd;
                    next_s.ad_oe_n = 1'b0;
                    next_s.req_o = 1'b1;
                    next_s.gap = REQ_GAP;
                    next_s.mst = M_ADDR;
                end
            end
            M_ADDR:
            begin
                next_s.frame_o = 1'b1;
                next_s.irdy_o = 1'b0;
                next_s.irdy_oe_n = 1'b0;
                next_s.ad_o = s.tx_data;
                next_s.cbe_o = BYTE_EN_ALL;
                next_s.wait_cnt = 3'h1;
                next_s.mst = M_DATA;
            end
            M_DATA:
            begin
                next_s.frame_oe_n = 1'b1;
                if (!link.primary_target_claim_n || s.wait_cnt == CLAIM_LIMIT)
                begin
                    next_s.done = !link.primary_target_claim_n;
                    next_s.abort = link.primary_target_claim_n;
                    next_s.irdy_o = 1'b1;
                    next_s.ad_oe_n = 1'b1;
                    next_s.mst = M_TURN;
                end
                else
                begin
                    next_s.wait_cnt = s.wait_cnt + 3'h1;
                end
            end
            M_TURN:
            begin
                next_s.irdy_oe_n = 1'b1;
                next_s.mst = M_IDLE;
            end
            default:
            begin
                next_s.mst = M_IDLE;
            end
        endcase
        // address, posted data and secondary errors
        serr_event = addr_err | posted_tgt_parity_err | !secondary_system_err_n;
        serr_event = serr_event | (s.abort & s.tx_posted) | posted_target_abort | posted_discard;
        serr_event = serr_event | delayed_write_discard | delayed_read_discard;
        serr_event = serr_event | delayed_master_timeout;
        next_s.serr_oe_n = !serr_event;
        next_s.speed_cap = async_mode ? link.primary_speed_select : config_speed_option;
        // secondary forced slow in synchronous mode
        next_s.sspeed_oe_n = async_mode;
    end

    // reset releases every bus output at once
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s <= DEV_RESET;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign link.dev_ad_o = s.ad_o;
    assign link.dev_cbe_o = s.cbe_o;
    assign link.dev_ad_oe_n = s.ad_oe_n;
    assign link.dev_par_o = s.par_o;
    assign link.dev_par_oe_n = s.par_oe_n;
    assign link.dev_frame_o = s.frame_o;
    assign link.dev_frame_oe_n = s.frame_oe_n;
    assign link.dev_irdy_o = s.irdy_o;
    assign link.dev_irdy_oe_n = s.irdy_oe_n;
    assign link.dev_req_o = s.req_o;
    assign link.dev_req_oe_n = s.req_oe_n;
    assign link.dev_perr_o = s.perr_o;
    assign link.dev_perr_oe_n = s.perr_oe_n;
    assign link.dev_serr_o = 1'b0;
    assign link.dev_serr_oe_n = s.serr_oe_n;
    assign mst_busy = s.mst != M_IDLE;
    assign mst_done = s.done;
    assign mst_abort = s.abort;
    assign cfg_claim = s.claim;
    assign cfg_claim_write = s.claim_wr;
    assign bus_locked = s.locked;
    assign secondary_speed_select_o = 1'b0;
    assign secondary_speed_select_oe_n = s.sspeed_oe_n;
    assign status_cmd_word = 32'(s.speed_cap) << SPEED_CAP_BIT;
endmodule

// ==== rtl/pps_host_end.sv ====
`timescale 1ns/100ps
module pps_host_end
(
    input logic clk,
    input logic rst,
    pps_link_if.host link,
    input logic [4:0] address,
    input logic read,
    input logic write,
    input logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest
);
    import pps_pkg::*;

    pps_host_state_type s;
    pps_host_state_type next_s;
    logic bus_idle;
    logic bad_par;
    logic [2:0] events;

    always_comb
    begin
        next_s = s;
        bus_idle = link.frame_n & link.irdy_n;
        next_s.prev_frame_n = link.frame_n;
        next_s.bus_ad = link.bus_ad;
        next_s.ack = (read | write) & !s.ack;
        if (read && !s.ack)
        begin
            case (address)
                REG_CTRL: next_s.rdata = 32'(s.ctrl);
                REG_ADDR: next_s.rdata = s.addr;
                REG_DATA: next_s.rdata = s.data;
                REG_CMD: next_s.rdata = {27'h0, s.pending | (s.hst != H_IDLE), s.cmd};
                REG_STATUS: next_s.rdata = {26'h0, s.seen, link.bus_req_n,
                    link.primary_system_err_n, link.primary_parity_err_n};
                REG_BUS: next_s.rdata = s.bus_ad;
                default: next_s.rdata = 32'h0;
            endcase
        end
        if (write && s.ack)
        begin
            case (address)
                REG_CTRL: next_s.ctrl = writedata[CTRL_W-1:0];
                REG_ADDR: next_s.addr = writedata;
                REG_DATA: next_s.data = writedata;
                REG_CMD:
                begin
                    next_s.cmd = writedata[3:0];
                    next_s.pending = 1'b1;
                end
                REG_STATUS: next_s.seen = s.seen & ~writedata[STAT_SEEN+2:STAT_SEEN];
                default: next_s.seen = next_s.seen;
            endcase
        end
        // Sticky captures, a new event beats the clear
        events = {!link.bus_req_n, !link.primary_system_err_n, !link.primary_parity_err_n};
        next_s.seen = next_s.seen | events;
        bad_par = s.hst == H_ADDR ? s.ctrl[CTRL_BAD_ADDR_PAR] : s.ctrl[CTRL_BAD_DATA_PAR];
        next_s.par_o = pps_parity(s.ad_o, s.cbe_o) ^ bad_par;
        next_s.par_oe_n = s.ad_oe_n;
        case (s.hst)
            H_IDLE:
            begin
                if (s.pending && !s.ctrl[CTRL_GRANT] && bus_idle)
                begin
                    next_s.pending = 1'b0;
                    next_s.frame_o = 1'b0;
                    next_s.frame_oe_n = 1'b0;
                    next_s.ad_o = s.addr;
                    next_s.cbe_o = s.cmd;
                    next_s.ad_oe_n = 1'b0;
                    next_s.hst = H_ADDR;
                end
            end
            H_ADDR:
            begin
                next_s.frame_o = 1'b1;
                next_s.irdy_o = 1'b0;
                next_s.irdy_oe_n = 1'b0;
                next_s.ad_o = s.data;
                next_s.cbe_o = BYTE_EN_ALL;
                next_s.hst = H_DATA;
            end
            H_DATA:
            begin
                next_s.frame_oe_n = 1'b1;
                next_s.irdy_o = 1'b1;
                next_s.ad_oe_n = 1'b1;
                next_s.hst = H_TURN;
            end
            H_TURN:
            begin
                next_s.irdy_oe_n = 1'b1;
                next_s.hst = H_IDLE;
            end
            default:
            begin
                next_s.hst = H_IDLE;
            end
        endcase
        // Target claim: drive high one cycle before release
        if (!s.devsel_oe_n && !s.devsel_o)
        begin
            next_s.devsel_o = 1'b1;
        end
        else
        begin
            next_s.devsel_oe_n = 1'b1;
        end
        if (s.prev_frame_n && !link.frame_n && s.frame_oe_n && s.ctrl[CTRL_CLAIM_EN])
        begin
            next_s.armed = 1'b1;
            next_s.claim_cnt = s.ctrl[CTRL_DELAY+2:CTRL_DELAY];
        end
        else if (s.armed && s.claim_cnt == 3'h0)
        begin
            next_s.armed = 1'b0;
            next_s.devsel_o = 1'b0;
            next_s.devsel_oe_n = 1'b0;
        end
        else if (s.armed)
        begin
            next_s.claim_cnt = s.claim_cnt - 3'h1;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s <= HOST_RESET;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign waitrequest = (read | write) & !s.ack;
    assign readdata = s.rdata;
    assign link.host_ad_o = s.ad_o;
    assign link.host_cbe_o = s.cbe_o;
    assign link.host_ad_oe_n = s.ad_oe_n;
    assign link.host_par_o = s.par_o;
    assign link.host_par_oe_n = s.par_oe_n;
    assign link.host_frame_o = s.frame_o;
    assign link.host_frame_oe_n = s.frame_oe_n;
    assign link.host_irdy_o = s.irdy_o;
    assign link.host_irdy_oe_n = s.irdy_oe_n;
    assign link.host_devsel_o = s.devsel_o;
    assign link.host_devsel_oe_n = s.devsel_oe_n;
    // shared error line only pulled low
    assign link.host_serr_o = 1'b0;
    assign link.host_serr_oe_n = !s.ctrl[CTRL_SERR];
    // lock held by software across the sequence
    assign link.host_lock_o = !s.ctrl[CTRL_LOCK];
    assign link.host_lock_oe_n = 1'b0;
    assign link.bus_gnt_n = !s.ctrl[CTRL_GRANT];
    assign link.primary_config_select = s.ctrl[CTRL_CFG_SEL];
    assign link.primary_speed_select = s.ctrl[CTRL_SPEED];
endmodule

// ==== tb/pps_assertions.sv ====
`timescale 1ns/100ps
module pps_assertions
    import pps_pkg::*;
(
    input logic clk,
    input logic rst,
    input logic [31:0] bus_ad,
    input logic [3:0] primary_cmd_byte_en,
    input logic primary_parity,
    input logic frame_n,
    input logic irdy_n,
    input logic bus_req_n,
    input logic bus_gnt_n,
    input logic primary_parity_err_n,
    input logic primary_system_err_n,
    input logic primary_target_claim_n,
    input logic dev_serr_o,
    input logic dev_serr_oe_n,
    input logic dev_perr_o,
    input logic dev_perr_oe_n,
    input logic dev_ad_oe_n,
    input logic dev_frame_oe_n,
    input logic host_frame_oe_n,
    input logic host_irdy_oe_n
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    a_req_gap: assert property ($rose(bus_req_n) |=> bus_req_n)
        else $error("request reasserted too soon");
    a_serr_pull: assert property (!dev_serr_oe_n |-> !dev_serr_o)
        else $error("system error driven high");
    a_perr_drop: assert property ($rose(dev_perr_oe_n) |-> $past(dev_perr_o))
        else $error("parity error released while low");
    a_perr_data: assert property ((!irdy_n && !host_irdy_oe_n ##1
        primary_parity != ^{$past(bus_ad), $past(primary_cmd_byte_en)}) |=> !primary_parity_err_n)
        else $error("data parity error not flagged");
    a_addr_par: assert property (($fell(frame_n) && !host_frame_oe_n ##1
        primary_parity != ^{$past(bus_ad), $past(primary_cmd_byte_en)}) |=> !primary_system_err_n)
        else $error("address parity error not flagged");
    a_park_idle: assert property ((frame_n && irdy_n && bus_req_n && !bus_gnt_n)[*3]
        |-> !dev_ad_oe_n && bus_ad == AD_PARK)
        else $error("idle granted bus not parked");
    a_start_grant: assert property ($fell(frame_n) && !dev_frame_oe_n |-> !$past(bus_gnt_n))
        else $error("transaction started without grant");
    a_abort_five: assert property (($fell(frame_n) && !dev_frame_oe_n ##1
        primary_target_claim_n[*5]) |=> irdy_n && dev_ad_oe_n)
        else $error("no master abort after five cycles");
    c_abort: cover property ($fell(frame_n) && !dev_frame_oe_n ##1 primary_target_claim_n[*5]);
    c_perr: cover property ($fell(primary_parity_err_n));
    c_park: cover property (!dev_ad_oe_n && frame_n && irdy_n && !bus_gnt_n);
endmodule

// ==== tb/tb_primary_pci_sideband_control.sv ====
`timescale 1ns/100ps
module tb_primary_pci_sideband_control;
    import pps_pkg::*;
    logic clk = 0;
    logic rst = 1;
    logic [4:0] address = '0;
    logic read = 0;
    logic write = 0;
    logic [31:0] writedata = '0;
    logic [31:0] ma = '0;
    logic [31:0] md = '0;
    logic [31:0] readdata, rd, hv, status_cmd_word;
    logic [3:0] mc = '0;
    logic [5:0] ev = '0;
    logic ms = 0, mp = 0, sec_n = 1, am = 0, cso = 0, e_m, e_c;
    logic waitrequest, busy, done, abrt, claim, claim_w, locked, sso, sso_oe_n;
    int n_fail = 0;
    int compares = 0;
    int seed = 32'hC0A6;
    int i;
    logic q_m[$];
    logic q_c[$];
    pps_link_if link();
    pps_bridge_end i_pps_bridge_end (.clk(clk), .rst(rst), .link(link.bridge), .mst_start(ms),
        .mst_addr(ma), .mst_cmd(mc), .mst_data(md), .mst_posted(mp), .mst_busy(busy),
        .mst_done(done), .mst_abort(abrt), .cfg_claim(claim), .cfg_claim_write(claim_w),
        .bus_locked(locked), .posted_tgt_parity_err(ev[0]), .posted_target_abort(ev[1]),
        .posted_discard(ev[2]), .delayed_write_discard(ev[3]), .delayed_read_discard(ev[4]),
        .delayed_master_timeout(ev[5]), .secondary_system_err_n(sec_n), .async_mode(am),
        .config_speed_option(cso), .secondary_speed_select_o(sso),
        .secondary_speed_select_oe_n(sso_oe_n), .status_cmd_word(status_cmd_word));
    pps_host_end i_pps_host_end (.clk(clk), .rst(rst), .link(link.host), .address(address),
        .read(read), .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest));
    pps_assertions i_pps_assertions (.clk(clk), .rst(rst), .bus_ad(link.bus_ad),
        .primary_cmd_byte_en(link.primary_cmd_byte_en), .primary_parity(link.primary_parity),
        .frame_n(link.frame_n), .irdy_n(link.irdy_n), .bus_req_n(link.bus_req_n),
        .bus_gnt_n(link.bus_gnt_n), .primary_parity_err_n(link.primary_parity_err_n),
        .primary_system_err_n(link.primary_system_err_n), .dev_serr_o(link.dev_serr_o),
        .primary_target_claim_n(link.primary_target_claim_n), .dev_perr_o(link.dev_perr_o),
        .dev_serr_oe_n(link.dev_serr_oe_n), .dev_perr_oe_n(link.dev_perr_oe_n),
        .dev_ad_oe_n(link.dev_ad_oe_n), .dev_frame_oe_n(link.dev_frame_oe_n),
        .host_frame_oe_n(link.host_frame_oe_n), .host_irdy_oe_n(link.host_irdy_oe_n));
    initial forever #10 clk = ~clk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        $display("compares %0d, n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic hang();
        n_fail++;
        conclude();
    endtask
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        logic w;
        int k;
        @(posedge clk);
        address <= a;
        writedata <= d;
        read <= !wr;
        write <= wr;
        for (k = 0; k < 20; k++)
        begin
            @(negedge clk);
            w = waitrequest;
            rd = readdata;
            @(posedge clk);
            if (w === 1'b0)
                break;
        end
        if (w !== 1'b0)
            hang();
        read <= 0;
        write <= 0;
    endtask
    task automatic busy_wait(input logic host);
        int k;
        for (k = 0; k < 40; k++)
        begin
            if (host)
                bus(0, REG_CMD, '0);
            else
                @(negedge clk);
            if ((host ? rd[STAT_CMD_BUSY] : busy) === 1'b0)
                return;
        end
        hang();
    endtask
    always @(negedge clk)
    begin
        if ((done | abrt) === 1'b1)
        begin
            e_m = q_m.size() ? q_m.pop_front() : 1'bx;
            chk(32'({done, abrt}), 32'({!e_m, e_m}));
        end
        if (claim === 1'b1)
        begin
            e_c = q_c.size() ? q_c.pop_front() : 1'bx;
            chk(32'(claim_w), 32'(e_c));
        end
    end
    initial
    begin
        repeat (6) @(posedge clk);
        rst <= 0;
        for (i = 0; i < 4; i++)
        begin
            am <= i[0];
            cso <= i[1];
            bus(1, REG_CTRL, 32'(!i[1]) << CTRL_SPEED);
            repeat (3) @(negedge clk);
            chk(status_cmd_word, 32'(i[0] ? !i[1] : i[1]) << SPEED_CAP_BIT);
            chk(32'({sso_oe_n, sso}), 32'({i[0], 1'b0}));
        end
        bus(0, 5'h18, '0);
        chk(rd, 32'h0);
        for (i = 0; i < 7; i++)
        begin
            bus(1, REG_STATUS, 32'h38);
            bus(0, REG_STATUS, '0);
            chk(32'(rd[STAT_SEEN + 1]), 32'h0);
            @(posedge clk);
            if (i < 6)
                ev[i] <= 1;
            else
                sec_n <= 0;
            @(posedge clk);
            ev <= '0;
            sec_n <= 1;
            bus(0, REG_STATUS, '0);
            chk(32'(rd[STAT_SEEN + 1]), 32'h1);
        end
        for (i = 0; i < 4; i++)
        begin
            bus(1, REG_STATUS, 32'h38);
            hv = $random(seed);
            hv[1:0] = 2'(i == 3);
            bus(1, REG_ADDR, hv);
            bus(1, REG_DATA, $random(seed));
            bus(1, REG_CTRL, {22'h0, i == 3, i == 2, 5'h0, i == 1, i != 2, 1'b0});
            if (i < 2)
                q_c.push_back(i == 0);
            bus(1, REG_CMD, 32'(i == 1 ? CMD_CFG_READ : CMD_CFG_WRITE));
            busy_wait(1);
            repeat (4) @(posedge clk);
            bus(0, REG_STATUS, '0);
            chk(32'(rd[5:3]), 32'({1'b0, i == 2, i == 3}));
            chk(32'(locked), 32'(i == 1));
        end
        bus(1, REG_STATUS, 32'h38);
        for (i = 0; i < 3; i++)
        begin
            bus(1, REG_CTRL, 32'h11 | ((i == 0 ? 0 : i + 2) << CTRL_DELAY));
            ma <= $random(seed);
            md <= $random(seed);
            mc <= 4'h7;
            mp <= (i == 2);
            ms <= 1;
            q_m.push_back(i == 2);
            @(posedge clk);
            ms <= 0;
            @(negedge clk);
            chk(32'(link.bus_req_n), 32'h0);
            busy_wait(0);
            bus(0, REG_STATUS, '0);
            chk(32'(rd[STAT_SEEN + 1]), 32'(i == 2));
        end
        rst <= 1;
        #2;
        chk(32'({link.dev_ad_oe_n, link.dev_par_oe_n, link.dev_req_oe_n}), 32'h7);
        @(posedge clk);
        rst <= 0;
        chk(32'(q_m.size() + q_c.size()), 32'h0);
        conclude();
    end
endmodule
